// file: rtl/i2cgc_pkg.sv
// shared constants for the two-wire slave engine with general call
package i2cgc_pkg;

	// ==========================================================
	// mode field codes (arbitrary plain defaults)
	localparam logic [3:0] MODE_MASTER    = 4'h8;
	localparam logic [3:0] MODE_SLV7      = 4'h6;
	localparam logic [3:0] MODE_SLV10     = 4'h7;
	localparam logic [3:0] MODE_FW_MASTER = 4'hB;
	localparam logic [3:0] MODE_SLV7_SS   = 4'hE;
	localparam logic [3:0] MODE_SLV10_SS  = 4'hF;

	// ==========================================================
	// address constants
	localparam logic [7:0] GC_ADDR        = 8'h00;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

	// ==========================================================
	// counts and reset values
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [7:0] ADDR_RST       = 8'h00;
	localparam logic [7:0] BUF_RST        = 8'h00;
	localparam logic       LINE_IDLE      = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_ACK   = 3'b010,
		ST_TX    = 3'b011,
		ST_TXACK = 3'b100
	} i2cgc_state_t;

	typedef enum logic [1:0] {
		KIND_ADDR1 = 2'b00,
		KIND_ADDR2 = 2'b01,
		KIND_DATA  = 2'b10
	} i2cgc_kind_t;

endpackage

// file: rtl/i2cgc_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module i2cgc_pin_sync #(
	parameter int   WIDTH     = 2,
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// ==========================================================
	// per-bit chain; s1 feeds only s2
	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		always_ff @(posedge core_clk_i) begin
			if (sys_rst_i) begin
				s1_q[g]    <= RESET_VAL;
				s2_q[g]    <= RESET_VAL;
				s3_q[g]    <= RESET_VAL;
				level_o[g] <= RESET_VAL;
			end else begin
				s1_q[g] <= pin_i[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
				// a change counts only once two stages agree
				if (s2_q[g] == s3_q[g]) begin
					level_o[g] <= s3_q[g];
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: rtl/i2cgc_bus_events.sv
// clock edges and start/stop detection on synchronised lines
`timescale 1ns/1ps
`default_nettype none
module i2cgc_bus_events (
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      start_o,
	output logic      stop_o
);

	logic scl_q;
	logic sda_q;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			scl_q <= i2cgc_pkg::LINE_IDLE;
			sda_q <= i2cgc_pkg::LINE_IDLE;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	assign scl_rise_o = scl_i & ~scl_q;
	assign scl_fall_o = ~scl_i & scl_q;
	// data moving while clock stays high marks a condition
	assign start_o    = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_o     = scl_i & scl_q & ~sda_q & sda_i;

endmodule
`default_nettype wire

// file: rtl/i2cgc_slave.sv
// two-wire slave engine with 7/10-bit and general call addressing
// ==========================================================
// Summary of operation
// RULE1: four-bit mode field picks master, slave 7/10-bit, with or without start/stop irq; master codes only leave the slave idle here
// RULE2: port works only while port enable bit is set
// RULE3: enabled two-wire mode with pins as inputs drives lines open-drain
// RULE4: matched address or data byte is acknowledged and copied into buffer
// RULE5: buffer full or overflow set means no ack, no load, irq still set
// RULE6: buffer read clears buffer full; overflow stays until software clears
// RULE7: wait for start, then shift eight bits on rising clock edges
// RULE8: shifter bits 7..1 compared with address on eighth falling edge
// RULE9: match loads buffer, sets full, acks; irq on ninth falling edge
// RULE10: 10-bit first byte is 11110, two high bits, write indication
// RULE11: high 10-bit byte sets irq, full, update-address; clock held till rewrite
// RULE12: low 10-bit byte sets same flags; address rewrite releases clock
// RULE13: high byte after repeated start for read sets irq and full only; the code also sets the read/write flag
// RULE14: matched write address clears read/write flag, address goes to buffer
// RULE15: irq flag set for every byte, cleared only by software
// RULE16: matched read address sets read/write flag, acks, then holds clock low
// RULE17: buffer write loads shifter; clock released only by release bit set
// RULE18: transmitted bits change on falling clock edges
// RULE19: master ack sampled on ninth rise; not-ack ends transfer and resets status
// RULE20: master checks clock is high before next pulse, allowing stretching
// RULE21: general call enable also matches all-zero write address
// RULE22: in 10-bit mode general call needs no second byte, no update-address
// RULE23: start and stop flags clear on reset and while disabled
// RULE24: byte arriving with buffer full sets overflow flag
`timescale 1ns/1ps
`default_nettype none
module i2cgc_slave (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_o,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       port_enable_bit_i,
	input  wire logic [3:0] mode_i,
	input  wire logic       general_call_enable_i,
	input  wire logic       scl_dir_in_i,
	input  wire logic       sda_dir_in_i,
	input  wire logic       addr_wr_i,
	input  wire logic [7:0] addr_wdata_i,
	output logic      [7:0] slave_addr_o,
	input  wire logic       buf_rd_i,
	input  wire logic       buf_wr_i,
	input  wire logic [7:0] buf_wdata_i,
	output logic      [7:0] rx_tx_buffer_o,
	input  wire logic       clock_release_set_i,
	input  wire logic       overflow_clr_i,
	input  wire logic       irq_clr_i,
	output logic            buffer_full_flag_o,
	output logic            receive_overflow_flag_o,
	output logic            serial_irq_flag_o,
	output logic            update_addr_flag_o,
	output logic            read_write_flag_o,
	output logic            start_seen_o,
	output logic            stop_seen_o,
	output logic            clock_release_bit_o
);

	// ==========================================================
	// pin sampling
	logic [1:0] lines;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;

	i2cgc_pin_sync #(
		.WIDTH     (2),
		.RESET_VAL (i2cgc_pkg::LINE_IDLE)
	) u_sync (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.pin_i      ({scl_i, sda_i}),
		.level_o    (lines)
	);

	i2cgc_bus_events u_events (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.scl_i      (lines[1]),
		.sda_i      (lines[0]),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start_det),
		.stop_o     (stop_det)
	);

	// ==========================================================
	// state
	i2cgc_pkg::i2cgc_state_t state_q;
	i2cgc_pkg::i2cgc_kind_t  kind_q;
	i2cgc_pkg::i2cgc_kind_t  next_kind_q;
	logic [7:0] shifter_q;
	logic [3:0] bit_cnt_q;
	logic       ack_q;
	logic       tx_next_q;
	logic       ua_hold_q;
	logic       mack_q;
	logic       ten_ok_q;
	logic       hold_q;
	logic [7:0] addr_q;
	logic [7:0] buf_q;
	logic       bf_q;
	logic       ov_q;
	logic       irq_q;
	logic       ua_q;
	logic       rw_q;
	logic       start_q;
	logic       stop_q;
	logic       ckp_q;

	// ==========================================================
	// mode decode
	logic slave_mode;
	logic ten_bit;
	logic ss_irq;
	logic active;

	// RULE1: mode field decode
	// master codes leave the slave idle; no master sequencer here
	assign ten_bit    = (mode_i == i2cgc_pkg::MODE_SLV10) |
	                    (mode_i == i2cgc_pkg::MODE_SLV10_SS);
	assign ss_irq     = (mode_i == i2cgc_pkg::MODE_SLV7_SS) |
	                    (mode_i == i2cgc_pkg::MODE_SLV10_SS);
	assign slave_mode = ten_bit | ss_irq | (mode_i == i2cgc_pkg::MODE_SLV7);
	// RULE2: enable gating
	// RULE3: pins must be set as inputs
	assign active     = port_enable_bit_i & slave_mode & scl_dir_in_i & sda_dir_in_i;

	// ==========================================================
	// address evaluation at the eighth falling edge
	logic byte_done;
	logic blocked;
	logic gc_hit;
	logic hi_hit;
	logic addr_match;
	logic is_read;
	logic need_ua;
	logic accept;
	logic refuse;
	logic ninth_fall;

	assign byte_done = active & (state_q == i2cgc_pkg::ST_RX) & scl_fall &
	                   (bit_cnt_q == i2cgc_pkg::BITS_PER_BYTE);
	assign blocked   = bf_q | ov_q;
	// RULE21: general call match
	assign gc_hit    = general_call_enable_i & (kind_q == i2cgc_pkg::KIND_ADDR1) &
	                   (shifter_q == i2cgc_pkg::GC_ADDR);
	// RULE8: compare bits 7..1
	assign hi_hit    = (shifter_q[7:1] == addr_q[7:1]);
	assign is_read   = (kind_q == i2cgc_pkg::KIND_ADDR1) & shifter_q[0] & ~gc_hit;

	always_comb begin
		addr_match = 1'b0;
		need_ua    = 1'b0;
		case (kind_q)
			i2cgc_pkg::KIND_ADDR1: begin
				if (ten_bit) begin
					// RULE10: 11110 prefix; read only after full address seen
					addr_match = gc_hit | (hi_hit &
					             (shifter_q[7:3] == i2cgc_pkg::TEN_BIT_PREFIX) &
					             (~shifter_q[0] | ten_ok_q));
					// RULE22: general call skips second byte
					need_ua    = ~gc_hit & ~shifter_q[0];
				end else begin
					addr_match = gc_hit | hi_hit;
				end
			end
			i2cgc_pkg::KIND_ADDR2: begin
				addr_match = (shifter_q == addr_q);
				need_ua    = 1'b1;
			end
			i2cgc_pkg::KIND_DATA: begin
				addr_match = 1'b1;
			end
			default: begin
				addr_match = 1'b0;
			end
		endcase
	end

	assign accept     = byte_done & addr_match & ~blocked;
	assign refuse     = byte_done & addr_match & blocked;
	assign ninth_fall = active & scl_fall &
	                    ((state_q == i2cgc_pkg::ST_ACK) | (state_q == i2cgc_pkg::ST_TXACK));

	// ==========================================================
	// byte sequencer
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !active) begin
			state_q     <= i2cgc_pkg::ST_IDLE;
			kind_q      <= i2cgc_pkg::KIND_ADDR1;
			next_kind_q <= i2cgc_pkg::KIND_ADDR1;
			bit_cnt_q   <= 4'h0;
			ack_q       <= 1'b0;
			tx_next_q   <= 1'b0;
			ua_hold_q   <= 1'b0;
			mack_q      <= 1'b0;
		end else if (stop_det) begin
			state_q <= i2cgc_pkg::ST_IDLE;
		end else if (start_det) begin
			// RULE7: start opens address reception
			state_q   <= i2cgc_pkg::ST_RX;
			kind_q    <= i2cgc_pkg::KIND_ADDR1;
			bit_cnt_q <= 4'h0;
		end else begin
			case (state_q)
				i2cgc_pkg::ST_IDLE: begin
					bit_cnt_q <= 4'h0;
				end
				i2cgc_pkg::ST_RX: begin
					// RULE7: sample on rising clock
					if (scl_rise && bit_cnt_q != i2cgc_pkg::BITS_PER_BYTE) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					if (byte_done) begin
						if (addr_match) begin
							// RULE4: acknowledge accepted byte
							// RULE5: no ack while blocked
							ack_q     <= ~blocked;
							tx_next_q <= is_read & ~blocked;
							ua_hold_q <= need_ua & ~blocked;
							state_q   <= i2cgc_pkg::ST_ACK;
							if (ten_bit && kind_q == i2cgc_pkg::KIND_ADDR1 && need_ua) begin
								next_kind_q <= i2cgc_pkg::KIND_ADDR2;
							end else begin
								next_kind_q <= i2cgc_pkg::KIND_DATA;
							end
						end else begin
							state_q <= i2cgc_pkg::ST_IDLE;
						end
					end
				end
				i2cgc_pkg::ST_ACK: begin
					if (scl_fall) begin
						ack_q     <= 1'b0;
						bit_cnt_q <= 4'h0;
						kind_q    <= next_kind_q;
						if (tx_next_q) begin
							state_q <= i2cgc_pkg::ST_TX;
						end else if (kind_q == i2cgc_pkg::KIND_DATA || ack_q) begin
							state_q <= i2cgc_pkg::ST_RX;
						end else begin
							state_q <= i2cgc_pkg::ST_IDLE;
						end
					end
				end
				i2cgc_pkg::ST_TX: begin
					// RULE18: bits change on falling clock
					if (scl_fall) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == i2cgc_pkg::BITS_PER_BYTE - 4'h1) begin
							state_q <= i2cgc_pkg::ST_TXACK;
						end
					end
				end
				i2cgc_pkg::ST_TXACK: begin
					// RULE19: latch master ack on ninth rise
					if (scl_rise) begin
						mack_q <= lines[0];
					end
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						state_q   <= mack_q ? i2cgc_pkg::ST_IDLE : i2cgc_pkg::ST_TX;
					end
				end
				default: begin
					state_q <= i2cgc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// shift register
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			shifter_q <= i2cgc_pkg::BUF_RST;
		end else if (buf_wr_i && state_q != i2cgc_pkg::ST_RX) begin
			// RULE17: buffer write loads the shifter
			shifter_q <= buf_wdata_i;
		end else if (state_q == i2cgc_pkg::ST_RX && scl_rise) begin
			shifter_q <= {shifter_q[6:0], lines[0]};
		end else if (state_q == i2cgc_pkg::ST_TX && scl_fall) begin
			shifter_q <= {shifter_q[6:0], 1'b0};
		end
	end

	// ==========================================================
	// address register and buffer
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			addr_q <= i2cgc_pkg::ADDR_RST;
		end else if (addr_wr_i) begin
			addr_q <= addr_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			buf_q <= i2cgc_pkg::BUF_RST;
		end else if (accept) begin
			// RULE4: copy shifter into buffer
			// RULE14: address lands in buffer too
			buf_q <= shifter_q;
		end else if (buf_wr_i) begin
			buf_q <= buf_wdata_i;
		end
	end

	// ==========================================================
	// status flags; a hardware set wins over a same-cycle clear
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bf_q <= 1'b0;
		end else if (accept) begin
			// RULE9: buffer full on match
			bf_q <= 1'b1;
		end else if (buf_rd_i) begin
			// RULE6: read clears buffer full
			bf_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ov_q <= 1'b0;
		end else if (refuse && bf_q) begin
			// RULE24: lost byte marks overflow
			ov_q <= 1'b1;
		end else if (overflow_clr_i) begin
			// RULE6: software clears overflow
			ov_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b0;
		end else if (ninth_fall || (active && ss_irq && (start_det || stop_det))) begin
			// RULE15: every byte flags an interrupt
			// RULE9: set on ninth falling edge
			irq_q <= 1'b1;
		end else if (irq_clr_i) begin
			irq_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !active) begin
			ua_q <= 1'b0;
		end else if (accept && need_ua) begin
			// RULE11: high byte sets update-address
			// RULE12: low byte sets it again
			ua_q <= 1'b1;
		end else if (addr_wr_i) begin
			ua_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !active || stop_det) begin
			ten_ok_q <= 1'b0;
		end else if (accept && kind_q == i2cgc_pkg::KIND_ADDR2) begin
			// RULE13: full 10-bit match allows read after restart
			ten_ok_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !active) begin
			rw_q <= 1'b0;
		end else if (accept && kind_q == i2cgc_pkg::KIND_ADDR1) begin
			// RULE14: write clears it
			// RULE16: read sets it
			rw_q <= is_read;
		end else if (state_q == i2cgc_pkg::ST_TXACK && scl_fall && mack_q) begin
			// RULE19: not-ack resets status
			rw_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		// RULE23: clear on reset and disable
		if (sys_rst_i || !port_enable_bit_i) begin
			start_q <= 1'b0;
			stop_q  <= 1'b0;
		end else if (start_det) begin
			start_q <= 1'b1;
			stop_q  <= 1'b0;
		end else if (stop_det) begin
			start_q <= 1'b0;
			stop_q  <= 1'b1;
		end
	end

	// ==========================================================
	// clock stretching; relies on the master checking the line
	logic tx_hold_now;

	assign tx_hold_now = ninth_fall &
	                     ((state_q == i2cgc_pkg::ST_ACK) ? tx_next_q : ~mack_q);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ckp_q <= 1'b0;
		end else if (clock_release_set_i) begin
			ckp_q <= 1'b1;
		end else if (tx_hold_now) begin
			ckp_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !active || stop_det) begin
			hold_q <= 1'b0;
		end else if (tx_hold_now || (ninth_fall && ua_hold_q && state_q == i2cgc_pkg::ST_ACK)) begin
			// RULE16: hold clock after read ack
			// RULE11: hold until address rewrite
			hold_q <= 1'b1;
		end else if (ua_q ? addr_wr_i : clock_release_set_i) begin
			// RULE12: rewrite releases clock
			// RULE17: release bit releases clock
			// RULE20: master must wait for the line to rise
			hold_q <= 1'b0;
		end
	end

	// ==========================================================
	// open-drain pins
	// RULE3: only ever pull low
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_o = active & hold_q;
	assign sda_oe_o = active & (((state_q == i2cgc_pkg::ST_ACK) & ack_q) |
	                  ((state_q == i2cgc_pkg::ST_TX) & ~shifter_q[7]));

	assign slave_addr_o            = addr_q;
	assign rx_tx_buffer_o          = buf_q;
	assign buffer_full_flag_o      = bf_q;
	assign receive_overflow_flag_o = ov_q;
	assign serial_irq_flag_o       = irq_q;
	assign update_addr_flag_o      = ua_q;
	assign read_write_flag_o       = rw_q;
	assign start_seen_o            = start_q;
	assign stop_seen_o             = stop_q;
	assign clock_release_bit_o     = ckp_q;

endmodule
`default_nettype wire

// file: tb/i2cgc_assertions.sv
// concurrent checks on the two-wire slave engine ports
`timescale 1ns/1ps
`default_nettype none
module i2cgc_assertions (
	input wire logic       core_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       scl_i,
	input wire logic       scl_o,
	input wire logic       scl_oe_o,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       port_enable_bit_i,
	input wire logic       addr_wr_i,
	input wire logic [7:0] addr_wdata_i,
	input wire logic [7:0] slave_addr_o,
	input wire logic       buf_rd_i,
	input wire logic       clock_release_set_i,
	input wire logic       overflow_clr_i,
	input wire logic       irq_clr_i,
	input wire logic       buffer_full_flag_o,
	input wire logic       receive_overflow_flag_o,
	input wire logic       serial_irq_flag_o,
	input wire logic       update_addr_flag_o,
	input wire logic       start_seen_o,
	input wire logic       stop_seen_o,
	input wire logic       read_write_flag_o,
	input wire logic       clock_release_bit_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// transmit hold and its release
	sequence tx_hold;
		scl_oe_o && !update_addr_flag_o;
	endsequence
	sequence tx_go;
		!scl_oe_o && clock_release_bit_o;
	endsequence
	// ==========================================================
	// properties
	AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	AST_DIS_QUIET: assert property (!port_enable_bit_i [*2] |-> !scl_oe_o && !sda_oe_o)
		else $error("disabled port drives a line");
	AST_SS_CLR: assert property (!port_enable_bit_i |=> !start_seen_o && !stop_seen_o)
		else $error("start or stop flag kept while disabled");
	AST_BF_READ: assert property (buf_rd_i && scl_oe_o |=> !buffer_full_flag_o)
		else $error("buffer read left buffer full");
	AST_OVF_KEEP: assert property (receive_overflow_flag_o && !overflow_clr_i |=> receive_overflow_flag_o)
		else $error("overflow dropped by itself");
	AST_IRQ_KEEP: assert property (serial_irq_flag_o && !irq_clr_i |=> serial_irq_flag_o)
		else $error("irq dropped by itself");
	AST_UA_CLR: assert property (update_addr_flag_o && addr_wr_i |=> !update_addr_flag_o)
		else $error("address rewrite kept update flag");
	AST_UA_HOLD: assert property (update_addr_flag_o && scl_oe_o && !addr_wr_i |=> scl_oe_o)
		else $error("clock freed before address rewrite");
	AST_RELEASE: assert property (tx_hold ##0 clock_release_set_i |=> tx_go)
		else $error("release bit did not free the clock");
	AST_ADDR_WR: assert property (addr_wr_i |=> slave_addr_o == $past(addr_wdata_i))
		else $error("address write lost");
	AST_ACK_FREE: assert property ($rose(sda_oe_o) && !read_write_flag_o
		|-> !$past(buffer_full_flag_o) && !$past(receive_overflow_flag_o))
		else $error("ack given with buffer busy");
	AST_SDA_CHG: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed while clock high");
endmodule
`default_nettype wire

// file: tb/i2cgc_master_model.sv
// behavioural two-wire bus master driving the slave
`timescale 1ns/1ps
`default_nettype none
module i2cgc_master_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	// only ever pulls low, the pull-up supplies high
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic wait_scl;
		int n;
		n = 0;
		while (scl_i !== 1'b1 && n < 5000) begin
			#10;
			n++;
		end
	endtask
	task automatic start;
		sda_low_o = 1'b0;
		#40;
		scl_low_o = 1'b0;
		wait_scl();
		#40;
		sda_low_o = 1'b1;
		#40;
		scl_low_o = 1'b1;
		#40;
	endtask
	task automatic stop;
		sda_low_o = 1'b1;
		#40;
		scl_low_o = 1'b0;
		wait_scl();
		#40;
		sda_low_o = 1'b0;
		#80;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = !b;
		#40;
		scl_low_o = 1'b0;
		wait_scl();
		#40;
		r = sda_i;
		#40;
		scl_low_o = 1'b1;
		#40;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ai, ack);
	endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the two-wire slave engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       core_clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       port_enable_bit_i, general_call_enable_i, scl_dir_in_i, sda_dir_in_i;
	logic [3:0] mode_i;
	logic [7:0] addr_wdata_i, buf_wdata_i, slave_addr_o, rx_tx_buffer_o;
	logic [5:0] stb;
	logic       scl_o, scl_oe_o, sda_o, sda_oe_o, buffer_full_flag_o, receive_overflow_flag_o;
	logic       serial_irq_flag_o, update_addr_flag_o, read_write_flag_o, clock_release_bit_o;
	logic       start_seen_o, stop_seen_o, m_scl, m_sda;
	wire        scl_w = !(m_scl || scl_oe_o);
	wire        sda_w = !(m_sda || sda_oe_o);
	int         failures = 0;
	int         comparisons = 0;
	int         cycles = 0;

	i2cgc_slave uut (.core_clk_i, .sys_rst_i, .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w),
		.sda_o, .sda_oe_o, .port_enable_bit_i, .mode_i, .general_call_enable_i, .scl_dir_in_i,
		.sda_dir_in_i, .addr_wr_i(stb[0]), .addr_wdata_i, .slave_addr_o, .buf_rd_i(stb[1]),
		.buf_wr_i(stb[2]), .buf_wdata_i, .rx_tx_buffer_o, .clock_release_set_i(stb[3]),
		.overflow_clr_i(stb[4]), .irq_clr_i(stb[5]), .buffer_full_flag_o,
		.receive_overflow_flag_o, .serial_irq_flag_o, .update_addr_flag_o, .read_write_flag_o,
		.start_seen_o, .stop_seen_o, .clock_release_bit_o);
	i2cgc_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));

	always #5 core_clk_i = ~core_clk_i;
	// ==========================================================
	// hang guard, far above the expected run length
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			end_of_test();
		end
	end
	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic flags(input logic [4:0] e);
		chk("flags", {3'h0, e}, {3'h0, buffer_full_flag_o, receive_overflow_flag_o,
			serial_irq_flag_o, update_addr_flag_o, read_write_flag_o});
	endtask
	task automatic hold(input logic e);
		chk("hold", {7'h00, e}, {7'h00, scl_oe_o});
	endtask
	task automatic sw(input int k, input logic [7:0] d);
		@(negedge core_clk_i);
		addr_wdata_i = d;
		buf_wdata_i = d;
		stb[k] = 1'b1;
		@(negedge core_clk_i);
		stb = 6'h00;
	endtask
	task automatic drain;
		sw(1, 8'h00);
		sw(5, 8'h00);
	endtask
	task automatic cfg(input logic en, input logic dir, input logic [3:0] md, input logic gc);
		@(negedge core_clk_i);
		port_enable_bit_i = en;
		scl_dir_in_i = dir;
		sda_dir_in_i = dir;
		mode_i = md;
		general_call_enable_i = gc;
	endtask
	task automatic bx(input logic [7:0] tx, input logic ai, input logic ea, input logic [7:0] er);
		logic [7:0] rx;
		logic       a;
		m.xfer(tx, ai, rx, a);
		repeat (8) @(negedge core_clk_i);
		chk("ack", {7'h00, ea}, {7'h00, a});
		chk("byte", er, rx);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_w7;
		sw(0, 8'hA4);
		m.start();
		bx(8'hA4, 1'b1, 1'b0, 8'hA4);
		chk("buf", 8'hA4, rx_tx_buffer_o);
		flags(5'h14);
		drain();
		bx(8'h5A, 1'b1, 1'b0, 8'h5A);
		chk("buf", 8'h5A, rx_tx_buffer_o);
		sw(5, 8'h00);
		bx(8'h3C, 1'b1, 1'b1, 8'h3C);
		chk("buf", 8'h5A, rx_tx_buffer_o);
		flags(5'h1C);
		drain();
		flags(5'h08);
		sw(4, 8'h00);
		m.stop();
		m.start();
		bx(8'h42, 1'b1, 1'b1, 8'h42);
		flags(5'h00);
		m.stop();
	endtask
	task automatic t_gc;
		cfg(1'b1, 1'b1, i2cgc_pkg::MODE_SLV10, 1'b0);
		m.start();
		bx(8'h00, 1'b1, 1'b1, 8'h00);
		m.stop();
		cfg(1'b1, 1'b1, i2cgc_pkg::MODE_SLV10, 1'b1);
		m.start();
		bx(8'h00, 1'b1, 1'b0, 8'h00);
		flags(5'h14);
		drain();
		bx(8'h81, 1'b1, 1'b0, 8'h81);
		chk("buf", 8'h81, rx_tx_buffer_o);
		drain();
		m.stop();
	endtask
	task automatic t_rd;
		cfg(1'b1, 1'b1, i2cgc_pkg::MODE_SLV7, 1'b0);
		m.start();
		bx(8'hA5, 1'b1, 1'b0, 8'hA5);
		flags(5'h15);
		hold(1'b1);
		drain();
		sw(2, 8'h96);
		hold(1'b1);
		sw(3, 8'h00);
		chk("ckp", 8'h01, {7'h00, clock_release_bit_o});
		bx(8'hFF, 1'b0, 1'b0, 8'h96);
		hold(1'b1);
		chk("ckp", 8'h00, {7'h00, clock_release_bit_o});
		sw(5, 8'h00);
		sw(2, 8'h3C);
		sw(3, 8'h00);
		bx(8'hFF, 1'b1, 1'b1, 8'h3C);
		chk("rw", 8'h00, {7'h00, read_write_flag_o});
		hold(1'b0);
		m.stop();
	endtask
	task automatic t_10;
		cfg(1'b1, 1'b1, i2cgc_pkg::MODE_SLV10, 1'b0);
		sw(0, 8'hF2);
		m.start();
		bx(8'hF2, 1'b1, 1'b0, 8'hF2);
		flags(5'h16);
		hold(1'b1);
		sw(0, 8'h34);
		drain();
		hold(1'b0);
		bx(8'h34, 1'b1, 1'b0, 8'h34);
		flags(5'h16);
		hold(1'b1);
		sw(0, 8'hF2);
		flags(5'h14);
		hold(1'b0);
		drain();
		m.start();
		bx(8'hF3, 1'b1, 1'b0, 8'hF3);
		flags(5'h15);
		drain();
		sw(2, 8'hC5);
		sw(3, 8'h00);
		bx(8'hFF, 1'b1, 1'b1, 8'hC5);
		m.stop();
	endtask
	task automatic t_modes;
		logic [3:0] md [8] = '{i2cgc_pkg::MODE_MASTER, i2cgc_pkg::MODE_FW_MASTER,
			i2cgc_pkg::MODE_SLV7, i2cgc_pkg::MODE_SLV7_SS, i2cgc_pkg::MODE_SLV10,
			i2cgc_pkg::MODE_SLV10_SS, i2cgc_pkg::MODE_SLV7, i2cgc_pkg::MODE_SLV7};
		sw(0, 8'hA4);
		for (int k = 0; k < 8; k++) begin
			cfg(k != 6, k != 7, md[k], 1'b0);
			m.start();
			bx(8'hA4, 1'b1, !(k == 2 || k == 3), 8'hA4);
			if (k == 6) chk("start", 8'h00, {7'h00, start_seen_o});
			m.stop();
			drain();
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		port_enable_bit_i = 1'b1;
		general_call_enable_i = 1'b0;
		scl_dir_in_i = 1'b1;
		sda_dir_in_i = 1'b1;
		mode_i = i2cgc_pkg::MODE_SLV7;
		addr_wdata_i = 8'h00;
		buf_wdata_i = 8'h00;
		stb = 6'h00;
		repeat (20) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge core_clk_i);
		chk("idle", 8'h00, {buffer_full_flag_o, receive_overflow_flag_o, serial_irq_flag_o,
			update_addr_flag_o, start_seen_o, stop_seen_o, scl_oe_o, sda_oe_o});
		chk("addr", 8'h00, slave_addr_o);
		t_w7();
		t_gc();
		t_rd();
		t_10();
		t_modes();
		end_of_test();
	end
endmodule

bind i2cgc_slave i2cgc_assertions chk_i (.core_clk_i, .sys_rst_i, .scl_i, .scl_o, .scl_oe_o,
	.sda_o, .sda_oe_o, .port_enable_bit_i, .addr_wr_i, .addr_wdata_i, .slave_addr_o, .buf_rd_i,
	.clock_release_set_i, .overflow_clr_i, .irq_clr_i, .buffer_full_flag_o,
	.receive_overflow_flag_o, .serial_irq_flag_o, .update_addr_flag_o, .start_seen_o,
	.stop_seen_o, .read_write_flag_o, .clock_release_bit_o);
`default_nettype wire
